/* File: align_fifo.sv */
/*
 * Phase-align buffer: small FIFO with recentering and slip detection.
 * Assumes write and read strobes are one-cycle pulses on clk.
 */
module align_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic recenter,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  output logic [W-1:0] rd_data,
  output logic overflow,
  output logic underflow,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  // refuse a depth that the pointers cannot wrap cleanly
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  wire full = (level == (AW+1)'(DEPTH));
  wire empty = (level == '0);
  wire do_wr = wr_en && (!full || rd_en);
  wire do_rd = rd_en && !empty;
  assign overflow = wr_en && full && !rd_en;
  assign underflow = rd_en && empty;
  assign rd_data = mem[rptr];
  // pointers; recenter puts the read side half a buffer behind
  always_ff @(posedge clk) begin
    if (!nrst || recenter) begin
      wptr <= AW'(DEPTH / 2);
      rptr <= '0;
      level <= (AW+1)'(DEPTH / 2);
    end else begin
      if (do_wr) wptr <= wptr + 1'b1;
      if (do_rd) rptr <= rptr + 1'b1;
      level <= level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
  // storage
  always_ff @(posedge clk) begin
    if (do_wr) mem[wptr] <= wr_data;
  end
endmodule : align_fifo

/* File: edge_sync.sv */
/*
 * Two-flop synchroniser with a third stage for edge detection.
 * Assumes d is asynchronous to clk.
 */
module edge_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] q_d,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1;
  // s1 is read by q only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1 <= '0;
      q <= '0;
      q_d <= '0;
    end else begin
      s1 <= d;
      q <= s1;
      q_d <= q;
    end
  end
  // edges seen on the settled stages
  assign rise = q & ~q_d;
  assign fall = ~q & q_d;
endmodule : edge_sync

/* File: host_tx_model.sv */
/*
 * Host transmit logic model: drives the character pins and the host clock.
 * Assumes ref_clock_in comes from the bench; pins change on the falling
 * edge of the capture clock, so they are steady at each capture edge.
 */
module host_tx_model (
  input wire logic ref_clock_in,
  input wire logic use_host,
  input wire logic host_run,
  input wire logic [7:0] host_half_ns,
  input wire logic [9:0] word,
  output logic host_tx_clock_in,
  output logic [7:0] tx_char_in,
  output logic [1:0] tx_ctrl_in
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic cap_clk;

  // clock the host uses to launch its characters
  assign cap_clk = use_host ? host_tx_clock_in : ref_clock_in;

  // host clock at a rate set by the bench; pulled low while stopped
  initial begin
    host_tx_clock_in = 1'h0;
    forever begin
      if (host_run) begin
        #(host_half_ns) host_tx_clock_in = ~host_tx_clock_in;
      end else begin
        host_tx_clock_in = 1'h0;
        #7;
      end
    end
  end

  // launch the next character mid-period
  initial {tx_ctrl_in, tx_char_in} = 10'h000;
  always @(negedge cap_clk) begin
    {tx_ctrl_in, tx_char_in} <= word;
  end
endmodule : host_tx_model

/* File: test_tx_input_port.sv */
/*
 * Self-checking bench of the transmit input port.
 * Assumes the port, its package and host_tx_model; 100 MHz clk,
 * 160 ns reference clock made here.
 */
module test_tx_input_port import tx_align_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic word_sync_sent = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic ref_clock_in = 1'h0;
  logic ref_run = 1'h1;
  logic use_host = 1'h0;
  logic host_run = 1'h0;
  logic [7:0] host_half_ns = 8'h50;
  logic [9:0] word = 10'h0A5;
  logic host_tx_clock_in, tx_char_valid, synth_tx_clock_out, tx_path_error, irq;
  logic [7:0] tx_char_in;
  logic [1:0] tx_ctrl_in;
  tx_char_t tx_char_out;
  char_kind_t k;
  int error_cnt = 0;
  int cmp_count = 0;
  int n, g;

  // system clock
  always #5 clk = ~clk;

  // link clock, phase unrelated to clk, stands low while stopped
  initial begin
    #3;
    forever begin
      #80;
      ref_clock_in = ref_run ? ~ref_clock_in : 1'h0;
    end
  end

  tx_input_port dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ref_clock_in(ref_clock_in),
    .host_tx_clock_in(host_tx_clock_in), .tx_char_in(tx_char_in),
    .tx_ctrl_in(tx_ctrl_in), .word_sync_sent(word_sync_sent),
    .tx_char_out(tx_char_out), .tx_char_valid(tx_char_valid),
    .synth_tx_clock_out(synth_tx_clock_out), .tx_path_error(tx_path_error), .irq(irq));

  host_tx_model host (.ref_clock_in(ref_clock_in), .use_host(use_host),
    .host_run(host_run), .host_half_ns(host_half_ns), .word(word),
    .host_tx_clock_in(host_tx_clock_in), .tx_char_in(tx_char_in),
    .tx_ctrl_in(tx_ctrl_in));

  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task timeout;
    error_cnt++;
    $display("unexpected at %0t ns: wait ran out", $time);
    report_and_stop();
  endtask : timeout

  // register port: one-cycle strobes, read data one cycle later
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask : rd_reg

  task cycles(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cycles

  task wait_err(input logic e);
    n = 0;
    while (tx_path_error !== e) begin
      cycles(1);
      n++;
      if (n > 20000) timeout();
    end
  endtask : wait_err

  // wait for t character ticks
  task ticks(input int t);
    n = 0;
    while (t > 0) begin
      cycles(1);
      n++;
      if (tx_char_valid === 1'h1) t--;
      if (n > 20000) timeout();
    end
  endtask : ticks

  // clk cycles between two character ticks
  task gap;
    ticks(1);
    g = 0;
    do begin
      cycles(1);
      g++;
    end while (tx_char_valid !== 1'h1 && g < 100);
  endtask : gap

  // ticks between two self-test pass pulses
  task pass_gap;
    logic prev;
    wait_err(1'h0);
    wait_err(1'h1);
    g = 0;
    n = 0;
    prev = 1'h1;
    while (!(tx_path_error === 1'h1 && prev === 1'h0)) begin
      prev = tx_path_error;
      cycles(1);
      n++;
      if (tx_char_valid === 1'h1) g++;
      if (n > 20000) timeout();
    end
  endtask : pass_gap

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    cycles(1);
    check({tx_path_error, irq, tx_char_valid}, 32'h0);
    rd_reg(OFF_CTRL);
    check(v, {23'h0, CTRL_RST});
    rd_reg(OFF_MASK);
    check(v, 32'h0);
    wr_reg(8'h10, 32'hFFFF);
    rd_reg(8'h10);
    check(v, 32'h0);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      word = {c[1:0], 8'hA5};
      k = c[1] ? KIND_REPLACE : (c[0] ? KIND_SPECIAL : KIND_DATA);
      ticks(4);
      check(32'(tx_char_out), {20'h0, k, word});
      check(synth_tx_clock_out, 32'h1);
    end
    wr_reg(OFF_CTRL, 32'h15F);
    ticks(4);
    check(32'(tx_char_out), {20'h0, KIND_RAW, word});
    wr_reg(OFF_CTRL, 32'h19F);
    ticks(4);
    check(32'(tx_char_out), {20'h0, KIND_REPLACE, word});
    wr_reg(OFF_CTRL, 32'h11F);
    gap();
    check(g, 32'h10);
    wr_reg(OFF_CTRL, 32'h13F);
    gap();
    check(g, 32'h8);
    $display("test capture done");
    wr_reg(OFF_CTRL, 32'h11B);
    pass_gap();
    check(g, PASS_LEN_RX1);
    rd_reg(OFF_STATUS);
    check(v[ST_PASS], 32'h1);
    check(irq, 32'h0);
    wr_reg(OFF_CTRL, 32'h119);
    pass_gap();
    pass_gap();
    check(g, PASS_LEN_RX0);
    $display("test self-test done");
    wr_reg(OFF_CTRL, 32'h107);
    cycles(4);
    check(tx_path_error, 32'h1);
    rd_reg(OFF_STATE);
    check(v[SR_PLL_DOWN], 32'h1);
    ticks(0);
    g = 0;
    repeat (40) begin
      cycles(1);
      if (tx_char_valid === 1'h1) g++;
    end
    check(g, 32'h0);
    wr_reg(OFF_CTRL, 32'h11F);
    wait_err(1'h0);
    wr_reg(OFF_MASK, 32'h8);
    rd_reg(OFF_STATUS);
    ref_run = 1'h0;
    cycles(60);
    check({tx_path_error, irq}, 32'h3);
    rd_reg(OFF_STATUS);
    check(v[ST_REF_LOST], 32'h1);
    cycles(3);
    check(irq, 32'h0);
    ref_run = 1'h1;
    wait_err(1'h0);
    $display("test error sources done");
    word = 10'h3C5;
    use_host = 1'h1;
    host_run = 1'h1;
    wr_reg(OFF_CTRL, 32'h01E);
    wr_reg(OFF_CTRL, 32'h11E);
    ticks(20);
    check(tx_path_error, 32'h0);
    check(32'(tx_char_out), {20'h0, KIND_REPLACE, word});
    rd_reg(OFF_STATUS);
    host_half_ns = 8'h3C;
    wait_err(1'h1);
    rd_reg(OFF_STATUS);
    check(v[ST_OVERFLOW], 32'h1);
    rd_reg(OFF_STATE);
    check(v[SR_FAULT], 32'h1);
    host_half_ns = 8'h50;
    wr_reg(OFF_CTRL, 32'h11F);
    cycles(50);
    check(tx_path_error, 32'h1);
    @(posedge clk);
    word_sync_sent <= 1'h1;
    @(posedge clk);
    word_sync_sent <= 1'h0;
    cycles(4);
    check(tx_path_error, 32'h0);
    host_run = 1'h0;
    rd_reg(OFF_STATUS);
    wr_reg(OFF_CTRL, 32'h11E);
    wait_err(1'h1);
    rd_reg(OFF_STATUS);
    check(v[ST_UNDERFLOW], 32'h1);
    // leave host capture first, so no slip meets the recenter edge
    wr_reg(OFF_CTRL, 32'h11F);
    host_run = 1'h1;
    wr_reg(OFF_CTRL, 32'h01E);
    wr_reg(OFF_CTRL, 32'h11E);
    ticks(20);
    check(tx_path_error, 32'h0);
    check(32'(tx_char_out), {20'h0, KIND_REPLACE, word});
    $display("test align buffer done");
    report_and_stop();
  end
endmodule : test_tx_input_port

/* File: tx_align_pkg.sv */
/*
 * Package of the transmit input port: register offsets, field layout,
 * reset values, timing counts and the carrier types.
 * Assumes one 100 MHz system clock and a plain register port.
 */
package tx_align_pkg;
  // register offsets, byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0C;
  // status event bit positions
  localparam int ST_OVERFLOW = 0;
  localparam int ST_UNDERFLOW = 1;
  localparam int ST_PASS = 2;
  localparam int ST_REF_LOST = 3;
  localparam int ST_W = 4;
  // state register fields
  localparam int SR_ERR = 0;
  localparam int SR_FAULT = 1;
  localparam int SR_PLL_DOWN = 2;
  localparam int SR_LEVEL = 4;
  // reset values
  localparam logic [8:0] CTRL_RST = 9'h11F;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int REF_LOSS_NS = 320;
  localparam int REF_LOSS_CYC = (REF_LOSS_NS * CLK_MHZ + 999) / 1000;
  localparam int PASS_LEN_RX1 = 527;
  localparam int PASS_LEN_RX0 = 511;
  localparam int ALIGN_DEPTH = 4;
  // control latches, bit 0 is tx_clock_select
  typedef struct packed {
    logic align_buffer_reset;
    logic ref_half_rate;
    logic encoder_bypass;
    logic tx_rate_select;
    logic serial_out2_enable;
    logic serial_out1_enable;
    logic tx_selftest_enable_n;
    logic rx_clock_select;
    logic tx_clock_select;
  } ctrl_t;
  // how the encoder is to treat a character
  typedef enum logic [1:0] {
    KIND_DATA,
    KIND_SPECIAL,
    KIND_REPLACE,
    KIND_RAW
  } char_kind_t;
  typedef struct packed {
    char_kind_t kind;
    logic [9:0] bits;
  } tx_char_t;
endpackage : tx_align_pkg

/* File: tx_input_port.sv */
/*
 * Transmit parallel input port of one channel: capture, phase-align
 * buffer, character clock, self-test progress and error output.
 * Assumes pins and link clocks are asynchronous to clk; the register
 * port and word_sync_sent come from logic on clk.
 */
module tx_input_port
  import tx_align_pkg::*;
#(
  parameter int DEPTH = ALIGN_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic ref_clock_in,
  input wire logic host_tx_clock_in,
  input wire logic [7:0] tx_char_in,
  input wire logic [1:0] tx_ctrl_in,
  input wire logic word_sync_sent,
  output tx_char_t tx_char_out,
  output logic tx_char_valid,
  output logic synth_tx_clock_out,
  output logic tx_path_error,
  output logic irq
);
  localparam int LW = $clog2(DEPTH) + 1;
  // refuse a depth that the buffer pointers cannot wrap cleanly
  if (DEPTH < 2 || (1 << $clog2(DEPTH)) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two, two or more");
  end

  ctrl_t ctrl;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic buf_fault;
  logic ref_lost;
  logic [7:0] loss_cnt;
  logic [9:0] pass_cnt;
  logic pass_pulse;
  logic [9:0] cap_word;
  logic [7:0] per_cnt;
  logic [7:0] half_per;
  logic [LW-1:0] level;
  logic [9:0] fifo_out;
  logic ovf;
  logic unf;

  // pin synchronisers
  logic ref_rise;
  logic ref_fall;
  logic host_rise;
  logic [9:0] pins_d;
  edge_sync #(.W(1)) u_ref_sync (
    .clk(clk),
    .nrst(nrst),
    .d(ref_clock_in),
    .q(),
    .q_d(),
    .rise(ref_rise),
    .fall(ref_fall)
  );
  edge_sync #(.W(1)) u_host_sync (
    .clk(clk),
    .nrst(nrst),
    .d(host_tx_clock_in),
    .q(),
    .q_d(),
    .rise(host_rise),
    .fall()
  );
  edge_sync #(.W(10)) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .d({tx_ctrl_in, tx_char_in}),
    .q(),
    .q_d(pins_d),
    .rise(),
    .fall()
  );

  // register decode
  wire wr_ctrl = wr && (addr == OFF_CTRL);
  wire wr_mask = wr && (addr == OFF_MASK);
  wire rd_status = rd && (addr == OFF_STATUS);
  wire recenter = wr_ctrl && !wdata[8];
  wire host_sel = !ctrl.tx_clock_select;
  wire pll_down = !ctrl.serial_out1_enable && !ctrl.serial_out2_enable;
  wire selftest_on = !ctrl.tx_selftest_enable_n;

  // character clock from reference edges
  wire ref_edge = ref_rise || ref_fall;
  wire char_tick = ctrl.tx_rate_select ? ref_edge : ref_rise;
  // capture strobe for the selected interface clock
  wire ref_cap = (ctrl.ref_half_rate ? ref_edge : ref_rise);
  wire cap_strobe = host_sel ? host_rise : ref_cap;

  // phase-align buffer, used only with the host clock
  wire fifo_wr = host_sel && cap_strobe;
  wire fifo_rd = host_sel && char_tick && !pll_down;
  align_fifo #(.W(10), .DEPTH(DEPTH)) u_align (
    .clk(clk),
    .nrst(nrst),
    .recenter(recenter),
    .wr_en(fifo_wr),
    .wr_data(pins_d),
    .rd_en(fifo_rd),
    .rd_data(fifo_out),
    .overflow(ovf),
    .underflow(unf),
    .level(level)
  );

  wire slip_ovf = host_sel && ovf;
  wire slip_unf = host_sel && unf;
  wire [9:0] src = host_sel ? fifo_out : cap_word;
  wire [9:0] pass_end = ctrl.rx_clock_select ? 10'(PASS_LEN_RX1 - 1) : 10'(PASS_LEN_RX0 - 1);
  // at or past the end: a shorter period chosen mid-pass wraps at once
  wire pass_last = pass_cnt >= pass_end;
  wire [ST_W-1:0] events;
  assign events[ST_OVERFLOW] = slip_ovf;
  assign events[ST_UNDERFLOW] = slip_unf;
  assign events[ST_PASS] = selftest_on && char_tick && pass_last;
  assign events[ST_REF_LOST] = !ref_lost && !ref_edge && (loss_cnt == 8'(REF_LOSS_CYC - 1));
  wire fault_clear = word_sync_sent || recenter;
  wire next_error = pll_down || ref_lost || buf_fault || (selftest_on && pass_pulse);

  // kind of character for the encoder
  function automatic tx_char_t classify(input logic bypass, input logic [9:0] w);
    tx_char_t c;
    c.bits = w;
    if (bypass) c.kind = KIND_RAW;
    else if (w[9]) c.kind = KIND_REPLACE;
    else if (w[8]) c.kind = KIND_SPECIAL;
    else c.kind = KIND_DATA;
    return c;
  endfunction : classify

  // control register; align reset bit is stored as written
  always_ff @(posedge clk) begin
    if (!nrst) ctrl <= ctrl_t'(CTRL_RST);
    else if (wr_ctrl) ctrl <= ctrl_t'(wdata[8:0]);
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (!nrst) mask <= MASK_RST;
    else if (wr_mask) mask <= wdata[ST_W-1:0];
  end

  // sticky status, read clears, a new event wins
  always_ff @(posedge clk) begin
    if (!nrst) status <= '0;
    else status <= (rd_status ? '0 : status) | events;
  end

  // read data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk) begin
    if (!nrst || !rd) rdata <= '0;
    else begin
      case (addr)
        OFF_CTRL: rdata <= {23'h0, ctrl};
        OFF_STATUS: rdata <= {28'h0, status};
        OFF_MASK: rdata <= {28'h0, mask};
        OFF_STATE: rdata <= {24'h0, 4'(level), 1'b0, pll_down, buf_fault, tx_path_error};
        default: rdata <= '0;
      endcase
    end
  end

  // input capture register for the reference path
  always_ff @(posedge clk) begin
    if (!nrst) cap_word <= '0;
    else if (cap_strobe) cap_word <= pins_d;
  end

  // buffer fault, set wins over clear
  always_ff @(posedge clk) begin
    if (!nrst) buf_fault <= 1'b0;
    else if (slip_ovf || slip_unf) buf_fault <= 1'b1;
    else if (fault_clear) buf_fault <= 1'b0;
  end

  // reference loss watchdog
  always_ff @(posedge clk) begin
    if (!nrst || ref_edge) begin
      loss_cnt <= '0;
      ref_lost <= 1'b0;
    end else if (!ref_lost) begin
      loss_cnt <= loss_cnt + 8'h01;
      ref_lost <= loss_cnt == 8'(REF_LOSS_CYC - 1);
    end
  end

  // self-test pass counter and one-character pulse
  always_ff @(posedge clk) begin
    if (!nrst || !selftest_on) begin
      pass_cnt <= '0;
      pass_pulse <= 1'b0;
    end else if (char_tick) begin
      pass_cnt <= pass_last ? 10'h000 : pass_cnt + 10'h001;
      pass_pulse <= pass_last;
    end
  end

  // character handed to the encoder once per character time
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_char_out <= '0;
      tx_char_valid <= 1'b0;
    end else begin
      tx_char_valid <= char_tick && !pll_down;
      if (char_tick && !pll_down) tx_char_out <= classify(ctrl.encoder_bypass, src);
    end
  end

  // synthesized clock: high at each tick, low halfway
  always_ff @(posedge clk) begin
    if (!nrst) begin
      per_cnt <= '0;
      half_per <= '0;
      synth_tx_clock_out <= 1'b0;
    end else if (char_tick) begin
      per_cnt <= 8'h01;
      half_per <= {1'b0, per_cnt[7:1]};
      synth_tx_clock_out <= !pll_down;
    end else begin
      if (per_cnt != 8'hFF) per_cnt <= per_cnt + 8'h01;
      if (per_cnt >= half_per) synth_tx_clock_out <= 1'b0;
    end
  end

  // error output and interrupt, registered on clk
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_path_error <= 1'b0;
      irq <= 1'b0;
    end else begin
      tx_path_error <= next_error;
      irq <= |(status & mask);
    end
  end

  // checks
  AST_PLL_DOWN: assert property (@(posedge clk) disable iff (!nrst)
    pll_down |=> tx_path_error) else $error("error low while pll down");
  AST_REF_LOST: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ref_lost) |=> tx_path_error) else $error("error low on lost ref");
  AST_FAULT_SET: assert property (@(posedge clk) disable iff (!nrst)
    (slip_ovf || slip_unf) |=> buf_fault ##1 tx_path_error)
    else $error("slip not reported");
  AST_FAULT_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    buf_fault && !fault_clear |=> buf_fault) else $error("fault dropped early");
  AST_RECENTER: assert property (@(posedge clk) disable iff (!nrst)
    recenter && !slip_ovf && !slip_unf |=> !buf_fault && level == LW'(DEPTH / 2))
    else $error("recenter failed");
  AST_CAPTURE: assert property (@(posedge clk) disable iff (!nrst)
    cap_strobe |=> cap_word == $past(pins_d)) else $error("capture missed");
  AST_SELECT: assert property (@(posedge clk) disable iff (!nrst)
    host_rise && !ref_edge && !host_sel |-> !cap_strobe) else $error("wrong capture clock");
  AST_BYPASS: assert property (@(posedge clk) disable iff (!nrst)
    char_tick && !pll_down && ctrl.encoder_bypass |=>
    tx_char_out.kind == KIND_RAW && tx_char_out.bits == $past(src))
    else $error("bypass word wrong");
  AST_PASS_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    selftest_on && char_tick && pass_last && !pll_down && !ref_lost |=>
    pass_pulse ##1 tx_path_error) else $error("no pass pulse");
  AST_PASS_COUNT: assert property (@(posedge clk) disable iff (!nrst)
    selftest_on && char_tick && !pass_last |=> pass_cnt == $past(pass_cnt) + 10'h001)
    else $error("pass count skipped");

  // error output timing and its sources
  AST_ERR_REG: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> tx_path_error == $past(next_error))
    else $error("error not registered");
  AST_ERR_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    !pll_down && !ref_lost && !buf_fault && !pass_pulse |=> !tx_path_error)
    else $error("error high with no source");
  AST_LOSS_TIME: assert property (@(posedge clk) disable iff (!nrst)
    !ref_edge && !ref_lost && loss_cnt == 8'(REF_LOSS_CYC - 1) |=> ref_lost)
    else $error("reference loss not flagged");
  AST_FAULT_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    buf_fault && fault_clear && !slip_ovf && !slip_unf |=> !buf_fault)
    else $error("fault not cleared");
  AST_HOST_ONLY: assert property (@(posedge clk) disable iff (!nrst)
    !host_sel |-> !events[ST_OVERFLOW] && !events[ST_UNDERFLOW])
    else $error("slip flagged on reference capture");
  AST_PASS_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    selftest_on && pass_pulse && !char_tick |=> pass_pulse)
    else $error("pass pulse cut short");

  // character clock, capture edges and gating
  AST_HALF_RATE: assert property (@(posedge clk) disable iff (!nrst)
    !host_sel && ctrl.ref_half_rate && ref_fall |-> cap_strobe)
    else $error("falling reference edge not sampled");
  AST_VALID_GATE: assert property (@(posedge clk) disable iff (!nrst)
    pll_down |=> !tx_char_valid)
    else $error("character passed while pll down");
  AST_SYNTH_TICK: assert property (@(posedge clk) disable iff (!nrst)
    char_tick && !pll_down |=> synth_tx_clock_out && tx_char_valid)
    else $error("clock out missed a tick");
  AST_CHAR_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !(char_tick && !pll_down) |=> $stable(tx_char_out))
    else $error("character changed between ticks");

  // sticky status and interrupt
  AST_STATUS_SET: assert property (@(posedge clk) disable iff (!nrst)
    |events |=> (status & $past(events)) == $past(events))
    else $error("event not kept in status");
  AST_IRQ: assert property (@(posedge clk) disable iff (!nrst)
    |(status & mask) |=> irq)
    else $error("interrupt missing");

  COV_SLIP: cover property (@(posedge clk) disable iff (!nrst) slip_ovf || slip_unf);
  COV_PASS: cover property (@(posedge clk) disable iff (!nrst) events[ST_PASS]);
  COV_CLEAR: cover property (@(posedge clk) disable iff (!nrst)
    buf_fault ##1 !buf_fault);
  COV_IRQ: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
  COV_HALF: cover property (@(posedge clk) disable iff (!nrst)
    ctrl.ref_half_rate && ref_fall && cap_strobe);
endmodule : tx_input_port
